/* File: verilog/cpc_cmd_top.sv */
// Purpose: compensation parameter command handler, Avalon-MM slave
// Assumes: single 25 MHz clock, async active-low reset
// Notes:   commands finish one cycle after the command write
//
// Notes on behaviour
// - offset get returns stored offset word quickly
// - altitude set stores word as metres
// - altitude starts at zero metres
// - altitude get returns stored altitude, idle only
// - pressure set accepted during periodic measurement
// - written pressure replaces altitude compensation
// - pressure set stores word as hectopascals
// - pressure starts at 101300 Pa
// - read/write bit picks pressure get or set
// - pressure get returns stored word, also periodic
// - temperature offset starts at four degrees
`timescale 1ns/1ps
`include "cpc_params.svh"

module cpc_cmd_top #(
	parameter int EXEC_MAX_CYCLES = `CPC_EXEC_MAX_US * `CPC_CLK_MHZ
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic      [15:0] altitude_m_out,
	output logic      [15:0] pressure_hpa_out,
	output logic      [15:0] temp_offset_out,
	output logic             pressure_override_out,
	output logic             periodic_out
);
	import cpc_pkg::*;

	cpc_regs_s   r_reg;
	cpc_regs_s   r_next;
	logic [7:0]  wcrc_calc;
	logic [7:0]  resp_crc_calc;
	logic [15:0] resp_sel;
	logic        crc_ok;
	logic        exec;

	// ------------------------------------------------------------
	// check bytes
	// ------------------------------------------------------------
	cpc_crc8 u_crc_wr (
		.word_in (r_reg.wword),
		.crc_out (wcrc_calc)
	);
	cpc_crc8 u_crc_rd (
		.word_in (resp_sel),
		.crc_out (resp_crc_calc)
	);

	assign crc_ok = (wcrc_calc == r_reg.wcrc);
	assign exec   = (r_reg.state == CPC_EXEC);

	always_comb begin
		if (r_reg.cmd == `CPC_CMD_TOFF_GET) begin
			resp_sel = r_reg.toff;
		end else if (r_reg.cmd == `CPC_CMD_ALT_GET) begin
			resp_sel = r_reg.alt;
		end else begin
			resp_sel = r_reg.pres;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		r_next     = r_reg;
		r_next.ack = 1'b0;
		// one wait cycle, then a single ack cycle per request
		if ((avs_read_in || avs_write_in) && !r_reg.ack) begin
			r_next.ack = 1'b1;
			if (avs_read_in) begin
				if (avs_address_in == `CPC_OFS_CMD) begin
					r_next.rdata = {15'h0000, r_reg.cmd_rd, r_reg.cmd};
				end else if (avs_address_in == `CPC_OFS_WDATA) begin
					r_next.rdata = {8'h00, r_reg.wcrc, r_reg.wword};
				end else if (avs_address_in == `CPC_OFS_RDATA) begin
					r_next.rdata = {8'h00, r_reg.resp_crc, r_reg.resp};
				end else if (avs_address_in == `CPC_OFS_STATUS) begin
					r_next.rdata = {28'h000_0000, r_reg.periodic,
						r_reg.refused, r_reg.crc_err, r_reg.done};
				end else if (avs_address_in == `CPC_OFS_MODE) begin
					r_next.rdata = {31'h0000_0000, r_reg.periodic};
				end else begin
					r_next.rdata = 32'h0000_0000;
				end
			end
		end
		// waitrequest has its own flop so the pin sits behind no gate
		r_next.waitreq = !r_next.ack;
		// writes land on the ack edge; partial words are ignored
		if (r_reg.ack && avs_write_in && avs_byteenable_in == 4'hF) begin
			if (avs_address_in == `CPC_OFS_CMD) begin
				if (!exec) begin
					r_next.cmd     = avs_writedata_in[15:0];
					r_next.cmd_rd  = avs_writedata_in[`CPC_CMD_RD_BIT];
					r_next.state   = CPC_EXEC;
					r_next.done    = 1'b0;
					r_next.crc_err = 1'b0;
					r_next.refused = 1'b0;
				end
			end else if (avs_address_in == `CPC_OFS_WDATA) begin
				r_next.wword = avs_writedata_in[15:0];
				r_next.wcrc  = avs_writedata_in[23:16];
			end else if (avs_address_in == `CPC_OFS_STATUS) begin
				if (avs_writedata_in[`CPC_ST_DONE_BIT]) begin
					r_next.done = 1'b0;
				end
				if (avs_writedata_in[`CPC_ST_CRC_BIT]) begin
					r_next.crc_err = 1'b0;
				end
				if (avs_writedata_in[`CPC_ST_REF_BIT]) begin
					r_next.refused = 1'b0;
				end
			end else if (avs_address_in == `CPC_OFS_MODE) begin
				r_next.periodic = avs_writedata_in[`CPC_MODE_PER_BIT];
			end
		end
		// execution comes last so its flags win over a clear
		case (r_reg.state)
			CPC_IDLE: begin
			end
			CPC_EXEC: begin
				r_next.state = CPC_IDLE;
				r_next.done  = 1'b1;
				if (r_reg.cmd == `CPC_CMD_TOFF_GET) begin
					r_next.resp     = resp_sel;
					r_next.resp_crc = resp_crc_calc;
				end else if (r_reg.cmd == `CPC_CMD_ALT_GET) begin
					if (r_reg.periodic) begin
						r_next.refused = 1'b1;
					end else begin
						r_next.resp     = resp_sel;
						r_next.resp_crc = resp_crc_calc;
					end
				end else if (r_reg.cmd == `CPC_CMD_ALT_SET) begin
					if (r_reg.periodic) begin
						r_next.refused = 1'b1;
					end else if (!crc_ok) begin
						r_next.crc_err = 1'b1;
					end else begin
						r_next.alt = r_reg.wword;
					end
				end else if (r_reg.cmd == `CPC_CMD_PRES) begin
					if (r_reg.cmd_rd) begin
						r_next.resp     = resp_sel;
						r_next.resp_crc = resp_crc_calc;
					end else if (!crc_ok) begin
						r_next.crc_err = 1'b1;
					end else begin
						// accepted in any mode
						r_next.pres     = r_reg.wword;
						r_next.pres_set = 1'b1;
					end
				end else begin
					r_next.refused = 1'b1;
				end
			end
			default: begin
				r_next.state = CPC_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_reg          <= '0;
			r_reg.state    <= CPC_IDLE;
			r_reg.alt      <= `CPC_ALT_RESET;
			r_reg.pres     <= `CPC_PRES_RESET;
			r_reg.toff     <= `CPC_TOFF_RESET;
			r_reg.wcrc     <= `CPC_CRC_INIT;
			r_reg.waitreq  <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata_out      = r_reg.rdata;
	assign avs_waitrequest_out   = r_reg.waitreq;
	assign altitude_m_out        = r_reg.alt;
	assign pressure_hpa_out      = r_reg.pres;
	assign temp_offset_out       = r_reg.toff;
	assign pressure_override_out = r_reg.pres_set;
	assign periodic_out          = r_reg.periodic;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// helper: cycles from command write to done
	int busy_cnt;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_cnt <= 0;
		end else if (exec) begin
			busy_cnt <= busy_cnt + 1;
		end else begin
			busy_cnt <= 0;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_exec_cmd(logic [15:0] code);
		exec && r_reg.cmd == code;
	endsequence
	sequence s_finished;
		##1 (r_reg.done && r_reg.state == CPC_IDLE);
	endsequence

	a_exec_time_bound: assert property (
		exec |-> busy_cnt < EXEC_MAX_CYCLES ##1 !exec)
		else $error("command took too long");
	a_toff_reply_word: assert property (
		s_exec_cmd(`CPC_CMD_TOFF_GET) |-> s_finished
		##0 (r_reg.resp == $past(r_reg.toff)))
		else $error("offset reply wrong");
	a_alt_store_word: assert property (
		s_exec_cmd(`CPC_CMD_ALT_SET) ##0 (!r_reg.periodic && crc_ok)
		|=> altitude_m_out == $past(r_reg.wword))
		else $error("altitude not stored");
	a_alt_only_set: assert property (
		!(exec && r_reg.cmd == `CPC_CMD_ALT_SET) |=> $stable(r_reg.alt))
		else $error("altitude changed without set");
	a_alt_idle_only: assert property (
		exec && r_reg.periodic && (r_reg.cmd == `CPC_CMD_ALT_GET
		|| r_reg.cmd == `CPC_CMD_ALT_SET)
		|=> r_reg.refused && $stable(r_reg.alt) && $stable(r_reg.resp))
		else $error("altitude command not refused");
	a_pres_store_word: assert property (
		s_exec_cmd(`CPC_CMD_PRES) ##0 (!r_reg.cmd_rd && crc_ok)
		|=> pressure_hpa_out == $past(r_reg.wword) && pressure_override_out)
		else $error("pressure not stored");
	a_pres_override_hold: assert property (
		pressure_override_out |=> pressure_override_out)
		else $error("pressure override dropped");
	a_pres_default_val: assert property (
		!r_reg.pres_set |-> r_reg.pres == `CPC_PRES_RESET)
		else $error("pressure default lost");
	a_pres_get_form: assert property (
		s_exec_cmd(`CPC_CMD_PRES) ##0 r_reg.cmd_rd |-> s_finished
		##0 (r_reg.resp == $past(r_reg.pres)) && $stable(r_reg.pres))
		else $error("pressure get wrong");
	a_toff_default_val: assert property (
		temp_offset_out == `CPC_TOFF_RESET)
		else $error("offset default lost");
	a_crc_reject_word: assert property (
		exec && !r_reg.cmd_rd && !crc_ok && r_reg.cmd == `CPC_CMD_PRES
		|=> r_reg.crc_err && $stable(r_reg.pres))
		else $error("bad check byte accepted");
	a_resp_crc_match: assert property (
		exec ##1 r_reg.done |-> r_reg.resp_crc == u_crc_rd.crc_out
		|| r_reg.refused || r_reg.crc_err || $stable(r_reg.resp_crc))
		else $error("reply check byte wrong");
	a_bus_ack_next: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
		else $error("bus not answered");
	a_wait_one_cycle: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_ovr_rise_cause: assert property (
		$rose(pressure_override_out) |-> $past(exec)
		&& $past(r_reg.cmd) == `CPC_CMD_PRES && !$past(r_reg.cmd_rd))
		else $error("override without pressure set");
	a_pres_periodic_ok: assert property (
		s_exec_cmd(`CPC_CMD_PRES) ##0 (r_reg.periodic && !r_reg.cmd_rd
		&& crc_ok) |=> !r_reg.refused && pressure_override_out)
		else $error("pressure set refused in periodic");
	// unknown codes must not fall through as a silent success
	a_unknown_refused: assert property (
		exec && r_reg.cmd != `CPC_CMD_TOFF_GET
		&& r_reg.cmd != `CPC_CMD_ALT_GET && r_reg.cmd != `CPC_CMD_ALT_SET
		&& r_reg.cmd != `CPC_CMD_PRES |=> r_reg.refused && r_reg.done)
		else $error("unknown command not refused");
	a_cmd_clears_flags: assert property (
		$rose(exec) |-> !r_reg.done && !r_reg.crc_err && !r_reg.refused)
		else $error("flags not cleared by command");

endmodule // cpc_cmd_top

/* File: verilog/cpc_params.svh */
// Purpose: constants of the compensation parameter command block
// Assumes: 25 MHz core clock
// Notes:   byte offsets of the Avalon-MM register window
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CPC_OFS_CMD     5'h00
`define CPC_OFS_WDATA   5'h04
`define CPC_OFS_RDATA   5'h08
`define CPC_OFS_STATUS  5'h0C
`define CPC_OFS_MODE    5'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CPC_CMD_RD_BIT   16
`define CPC_ST_DONE_BIT  0
`define CPC_ST_CRC_BIT   1
`define CPC_ST_REF_BIT   2
`define CPC_ST_PER_BIT   3
`define CPC_MODE_PER_BIT 0

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CPC_CMD_TOFF_GET 16'h2318
`define CPC_CMD_ALT_SET  16'h2427
`define CPC_CMD_ALT_GET  16'h2322
`define CPC_CMD_PRES     16'hE000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CPC_ALT_RESET   16'h0000
`define CPC_PRES_RESET  16'h03F5
`define CPC_TOFF_RESET  16'h05DA

// ----------------------------------------------------------------
// check byte and timing
// ----------------------------------------------------------------
`define CPC_CRC_POLY    8'h31
`define CPC_CRC_INIT    8'hFF
`define CPC_CLK_MHZ     25
`define CPC_EXEC_MAX_US 1000

`endif

/* File: verilog/cpc_pkg.sv */
// Purpose: types of the compensation parameter command block
// Assumes: nothing
// Notes:   whole state of the top but busy_cnt lives in one packed struct
package cpc_pkg;

	typedef enum logic {
		CPC_IDLE,
		CPC_EXEC
	} cpc_state_e;

	typedef struct packed {
		cpc_state_e  state;
		logic        ack;
		logic        waitreq;
		logic [31:0] rdata;
		logic [15:0] cmd;
		logic        cmd_rd;
		logic [15:0] wword;
		logic [7:0]  wcrc;
		logic [15:0] resp;
		logic [7:0]  resp_crc;
		logic [15:0] alt;
		logic [15:0] pres;
		logic [15:0] toff;
		logic        pres_set;
		logic        periodic;
		logic        done;
		logic        crc_err;
		logic        refused;
	} cpc_regs_s;

endpackage

/* File: verilog/cpc_crc8.sv */
// Purpose: 8-bit check byte over one 16-bit word
// Assumes: purely combinational
// Notes:   msb first, high byte before low byte
`timescale 1ns/1ps
`include "cpc_params.svh"

module cpc_crc8 (
	input  wire logic [15:0] word_in,
	output logic      [7:0]  crc_out
);
	logic [7:0] c;
	always_comb begin
		c = `CPC_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ word_in[i]) begin
				c = {c[6:0], 1'b0} ^ `CPC_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule // cpc_crc8

/* File: sim/cpc_host_model.sv */
// Purpose: bus master standing in for the command-issuing host
// Assumes: called just after a rising edge of clk_in
// Notes:   waits for waitrequest without limit; bench watchdog ends hangs
`timescale 1ns/1ps

module cpc_host_model (
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	input  wire logic [31:0] readdata_in,
	output logic      [4:0]  address_out,
	output logic             read_out,
	output logic             write_out,
	output logic      [31:0] writedata_out,
	output logic      [3:0]  byteenable_out
);
	logic [3:0] be_sel;

	initial begin
		be_sel = 4'hF;
		address_out = 5'h1F;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h0000_0000;
		byteenable_out = 4'hF;
	end

	// one transfer, held until waitrequest is sampled low
	task xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		address_out <= a;
		writedata_out <= d;
		write_out <= wr;
		read_out <= !wr;
		byteenable_out <= be_sel;
		@(posedge clk_in);
		while (waitrequest_in !== 1'b0) @(posedge clk_in);
		q = readdata_in;
		read_out <= 1'b0;
		write_out <= 1'b0;
		// released lines must not keep looking valid
		address_out <= ~a;
		writedata_out <= ~d;
		@(posedge clk_in);
	endtask
endmodule // cpc_host_model

/* File: sim/test_compensation_param_commands.sv */
// Purpose: self-checking bench of the parameter command handler
// Assumes: 25 MHz clock, random stimulus from a fixed seed
// Notes:   expectations come from bench code only
`timescale 1ns/1ps
`include "cpc_params.svh"

module test_compensation_param_commands;
	logic        clk;
	logic        rst_n;
	logic [4:0]  address;
	logic        read;
	logic        write;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        wait_req;
	logic [15:0] alt;
	logic [15:0] pres;
	logic [15:0] toff;
	logic        ovr;
	logic        per;
	int          miscompares;
	int          tests_run;
	logic [31:0] seed;
	logic [31:0] st;
	logic [31:0] q;
	logic [15:0] v;
	logic [15:0] offs;
	logic [15:0] alt_exp;
	// host wait after stop, shortened: the block itself needs none
	localparam int STOP_WAIT_CYCLES = 50;

	initial clk = 1'b0;
	always #20 clk = ~clk;

	cpc_cmd_top i_cpc_cmd_top (
		.core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(address),
		.avs_read_in(read), .avs_write_in(write),
		.avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
		.altitude_m_out(alt), .pressure_hpa_out(pres),
		.temp_offset_out(toff), .pressure_override_out(ovr),
		.periodic_out(per));

	cpc_host_model i_cpc_host_model (
		.clk_in(clk), .waitrequest_in(wait_req), .readdata_in(rdata),
		.address_out(address), .read_out(read), .write_out(write),
		.writedata_out(wdata), .byteenable_out(be));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task cmd(input logic [15:0] code, input logic rdf, input logic [15:0] w,
		input logic [7:0] c);
		logic [31:0] x;
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_WDATA, {8'h00, c, w}, x);
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_CMD, {15'h0000, rdf, code}, x);
		i_cpc_host_model.xfer(1'b0, `CPC_OFS_STATUS, 32'h0000_0000, st);
		i_cpc_host_model.xfer(1'b0, `CPC_OFS_RDATA, 32'h0000_0000, q);
	endtask

	task stop_test;
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#800000;
		miscompares++;
		stop_test();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h2de1_5ff1;
		miscompares = 0;
		tests_run = 0;
		offs = 16'((4 * 65535 + 87) / 175);
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("altitude reset", alt, 16'h0000);
		chk("pressure reset", pres, 16'(101300 / 100));
		chk("offset reset", toff, offs);
		chk("override reset", ovr, 1'b0);
		cmd(`CPC_CMD_TOFF_GET, 1'b0, 16'h0000, 8'h00);
		chk("offset get", q[23:0], {crc8(offs), offs});
		chk("offset done", st[0], 1'b1);
		cmd(`CPC_CMD_PRES, 1'b1, 16'h0000, 8'h00);
		chk("pressure get", q[23:0], {crc8(16'h03F5), 16'h03F5});
		chk("check byte example", crc8(16'h0912), 8'h63);
		cmd(`CPC_CMD_ALT_SET, 1'b0, 16'h079E, 8'h09);
		chk("altitude example", alt, 16'd1950);
		chk("example status", st[2:0], 3'b001);
		cmd(`CPC_CMD_ALT_SET, 1'b0, 16'h044C, 8'h42);
		cmd(`CPC_CMD_ALT_GET, 1'b0, 16'h0000, 8'h00);
		chk("altitude get example", q[23:0], 24'h42_044C);
		cmd(16'h1234, 1'b0, 16'h0000, 8'h00);
		chk("unknown refused", st[2:0], 3'b101);
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_STATUS, 32'h0000_0007, q);
		i_cpc_host_model.xfer(1'b0, `CPC_OFS_STATUS, 32'h0000_0000, st);
		chk("status cleared", st[2:0], 3'b000);
		for (int i = 0; i < 6; i++) begin
			// altitude kept within 0 to 3000 m
			v = (i == 0) ? 16'd3000 : (i == 1) ? 16'd0 :
				16'($unsigned($random(seed)) % 3001);
			cmd(`CPC_CMD_ALT_SET, 1'b0, v, crc8(v));
			chk("altitude set", alt, v);
			chk("altitude status", st[2:0], 3'b001);
			cmd(`CPC_CMD_ALT_GET, 1'b0, 16'h0000, 8'h00);
			chk("altitude get", q[23:0], {crc8(v), v});
			cmd(`CPC_CMD_ALT_SET, 1'b0, v ^ 16'h0001, ~crc8(v ^ 16'h0001));
			chk("bad check flag", st[1], 1'b1);
			chk("bad check kept", alt, v);
		end
		i_cpc_host_model.be_sel = 4'h3;
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_MODE, 32'h0000_0001, q);
		i_cpc_host_model.be_sel = 4'hF;
		chk("partial write ignored", per, 1'b0);
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_MODE, 32'h0000_0001, q);
		chk("periodic mode", per, 1'b1);
		cmd(`CPC_CMD_ALT_SET, 1'b0, 16'h0007, crc8(16'h0007));
		chk("altitude refused", st[2], 1'b1);
		chk("altitude held", alt, v);
		cmd(`CPC_CMD_ALT_GET, 1'b0, 16'h0000, 8'h00);
		chk("altitude get refused", st[2], 1'b1);
		chk("altitude reply kept", q[23:0], {crc8(v), v});
		cmd(`CPC_CMD_TOFF_GET, 1'b0, 16'h0000, 8'h00);
		chk("offset get periodic", q[23:0], {crc8(offs), offs});
		alt_exp = v;
		cmd(`CPC_CMD_PRES, 1'b0, 16'h03DB, 8'h42);
		chk("pressure example", pres, 16'(98700 / 100));
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 16'd700 : (i == 1) ? 16'd1200 :
				16'(700 + $unsigned($random(seed)) % 501);
			cmd(`CPC_CMD_PRES, 1'b0, v, crc8(v));
			chk("pressure set", pres, v);
			chk("override", ovr, 1'b1);
			cmd(`CPC_CMD_PRES, 1'b1, 16'h0000, 8'h00);
			chk("pressure readback", q[23:0], {crc8(v), v});
		end
		i_cpc_host_model.xfer(1'b1, `CPC_OFS_MODE, 32'h0000_0000, q);
		chk("idle mode", per, 1'b0);
		repeat (STOP_WAIT_CYCLES) @(posedge clk);
		cmd(`CPC_CMD_ALT_GET, 1'b0, 16'h0000, 8'h00);
		chk("altitude get idle", q[23:0], {crc8(alt_exp), alt_exp});
		chk("altitude get status", st[2:0], 3'b001);
		i_cpc_host_model.xfer(1'b0, 5'h14, 32'h0000_0000, q);
		chk("unmapped read", q, 32'h0000_0000);
		// no persist was issued, so a reset must bring zero back
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("altitude after reset", alt, 16'h0000);
		chk("override after reset", ovr, 1'b0);
		chk("pressure after reset", pres, 16'(101300 / 100));
		v = 16'h0000;
		cmd(`CPC_CMD_ALT_GET, 1'b0, 16'h0000, 8'h00);
		chk("alt reset get", q[23:0], {crc8(v), v});
		stop_test();
	end
endmodule // test_compensation_param_commands
